//--- hw/input_scan_regs.vh
// input_scan_regs.vh: register offsets, field positions, reset values and timing counts
// for the eight-channel input scan block; included by the design files, definitions only
`ifndef INPUT_SCAN_REGS_VH
`define INPUT_SCAN_REGS_VH

// register word offsets (byte address = 4 * index)
`define REG_CTRL          8'h00
`define REG_STATUS        8'h01
`define REG_INT_STATE     8'h02
`define REG_OUT_STATE     8'h03
`define REG_CH_BASE       8'h10
`define CH_STRIDE         8'h04
`define CH_THRESH_OFS     2'd0
`define CH_DELAY_ON_OFS   2'd1
`define CH_DELAY_OFF_OFS  2'd2
`define CH_VOLT_OFS       2'd3

// ctrl register field positions
`define CTRL_POL_LSB      0
`define CTRL_AC_LSB       8
`define CTRL_BASE_LSB     16

// threshold register fields, volts in 1 V steps
`define TH_ACT_LSB        0
`define TH_REL_LSB        16
`define TH_ACT_RESET      16'h0058
`define TH_REL_RESET      16'h003C

// scan timing
`define SCAN_PERIOD_NS    5000000
`define CLK_PERIOD_NS     5
`define AC_DROP_MS        30
`define SCAN_MS           5
`define AC_PCT            10

`endif

//--- hw/channel_settings_mem.v
// channel_settings_mem.v: small per-channel settings memory, one write and one read port
// assumes a single clock; read data come out of a register one cycle after the address
`timescale 1ns/1ps

module channel_settings_mem #(
  parameter WIDTH = 32, // word width
  parameter DEPTH = 8,  // channel count
  parameter AW    = 3   // address width
) (
  input  wire             clk,
  input  wire             wr_en,
  input  wire [AW-1:0]    wr_addr,
  input  wire [WIDTH-1:0] wr_data,
  input  wire [AW-1:0]    rd_addr,
  output reg  [WIDTH-1:0] rd_data
);

  reg [WIDTH-1:0] mem [0:DEPTH-1]; // storage, no reset: software loads it

  // single write port
  always @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // registered read
  always @(posedge clk) begin
    rd_data <= mem[rd_addr];
  end

endmodule

//--- hw/scan_tick_gen.v
// scan_tick_gen.v: divider giving a one-cycle pulse once per scan cycle
// assumes clk at the rate the period count was derived for
`timescale 1ns/1ps

module scan_tick_gen #(
  parameter PERIOD = 1000000 // clock cycles per scan
) (
  input  wire clk,
  input  wire nrst,
  output reg  tick
);

  reg [31:0] count; // cycles into the current scan

  // free-running counter, pulse on wrap
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      count <= 32'h0000_0000;
      tick  <= 1'b0;
    end else if (count == PERIOD - 1) begin
      count <= 32'h0000_0000;
      tick  <= 1'b1;
    end else begin
      count <= count + 32'h0000_0001;
      tick  <= 1'b0;
    end
  end

endmodule

//--- hw/input_scan.v
// input_scan.v: scan and conditioning of the eight-channel input expansion card
// assumes channel voltages arrive as 1 V codes from an outside converter clock domain;
// software reaches settings over a plain strobe port with read data one cycle later
//
// Summary of operation
// - sample all inputs once every 5 ms scan
// - internal consumers see state one scan later
// - relay routing adds one more scan
// - eight channels numbered base plus one onward
// - compare voltage against 1 V thresholds
// - per-channel pick-up, release delay and polarity
// - normally open reports 1 when energized
// - activation delays rise, drop-off delays fall
// - AC mode: 30 ms drop, release 10 percent
// - activate above, release below, defaults 88/60
//
// Implementation choices: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`include "input_scan_regs.vh"

module input_scan #(
  parameter NCH        = 8,                                  // channels on the card
  parameter SCAN_CYC   = `SCAN_PERIOD_NS / `CLK_PERIOD_NS,   // cycles per scan
  parameter VW         = 8                                   // voltage code width
) (
  input  wire              clk,
  input  wire              nrst,
  input  wire [NCH*VW-1:0] volt_in,
  input  wire [7:0]        addr,
  input  wire [31:0]       wdata,
  input  wire              wr,
  input  wire              rd,
  output reg  [31:0]       rdata,
  output reg  [NCH-1:0]    scan_state,
  output reg  [NCH-1:0]    internal_state,
  output reg  [NCH-1:0]    relay_route_state,
  output wire [7:0]        first_channel_num,
  output reg               scan_tick
);

  // ac drop-off in whole scans; the 5 ms scan divides 30 ms exactly, so nothing is rounded
  localparam [15:0] AC_SCANS = `AC_DROP_MS / `SCAN_MS;
  // divisor turning the activation threshold into the forced ac release level
  localparam [15:0] AC_DIV   = 100 / `AC_PCT;

  // states of the per-slot sequencer that walks channels after each tick
  localparam ST_IDLE = 2'd0;
  localparam ST_READ = 2'd1;
  localparam ST_EVAL = 2'd2;

  // threshold compare without polarity (applied later); returns next raw state given hysteresis
  function raw_next;
    input [VW-1:0] v;
    input [15:0]   act;
    input [15:0]   rel;
    input          prev;
    begin
      if ({{(16-VW){1'b0}}, v} > act)
        raw_next = 1'b1;
      else if ({{(16-VW){1'b0}}, v} < rel)
        raw_next = 1'b0;
      else
        raw_next = prev;
    end
  endfunction

  // two-flop synchroniser on the converter codes
  reg [NCH*VW-1:0] volt_meta;
  reg [NCH*VW-1:0] volt_sync;
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      volt_meta <= {NCH*VW{1'b0}};
      volt_sync <= {NCH*VW{1'b0}};
    end else begin
      volt_meta <= volt_in;
      volt_sync <= volt_meta;
    end
  end

  // multi-bit codes may tear while the converter updates them; a channel's code is
  // only taken once it reads the same on two edges in a row
  reg [NCH*VW-1:0] volt_prev;   // synchronised codes one edge ago
  reg [NCH*VW-1:0] volt_stable; // codes that held still for two edges
  integer j;
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      volt_prev   <= {NCH*VW{1'b0}};
      volt_stable <= {NCH*VW{1'b0}};
    end else begin
      volt_prev <= volt_sync;
      for (j = 0; j < NCH; j = j + 1) begin
        if (volt_sync[j*VW +: VW] == volt_prev[j*VW +: VW])
          volt_stable[j*VW +: VW] <= volt_sync[j*VW +: VW];
      end
    end
  end

  // scan divider
  wire tick;
  scan_tick_gen #(.PERIOD(SCAN_CYC)) u_tick (
    .clk  (clk),
    .nrst (nrst),
    .tick (tick)
  );

  // control: polarity, ac mode, base channel number
  reg [NCH-1:0] pol_nc;      // 1 = normally closed
  reg [NCH-1:0] ac_mode;     // alternating current handling
  reg [7:0]     ch_base;     // inputs on preceding modules
  assign first_channel_num = ch_base + 8'h01;

  // settings memories: thresholds and delays per channel
  wire [7:0] ch_off      = addr - `REG_CH_BASE; // offset into the channel window
  wire       ch_space    = (addr >= `REG_CH_BASE) && (addr < `REG_CH_BASE + 8'h20);
  wire [2:0] ch_sel      = ch_off[4:2];         // channel counts from the window base
  wire [1:0] ch_field    = addr[1:0];
  reg  [2:0] seq_ch;         // channel being evaluated
  reg  [1:0] seq_state;      // sequencer state

  wire [31:0] th_q;
  wire [31:0] don_q;
  wire [31:0] doff_q;
  wire        th_we   = wr && ch_space && (ch_field == `CH_THRESH_OFS);
  wire        don_we  = wr && ch_space && (ch_field == `CH_DELAY_ON_OFS);
  wire        doff_we = wr && ch_space && (ch_field == `CH_DELAY_OFF_OFS);

  channel_settings_mem #(.WIDTH(32), .DEPTH(NCH), .AW(3)) u_th (
    .clk     (clk),
    .wr_en   (th_we),
    .wr_addr (ch_sel),
    .wr_data (wdata),
    .rd_addr (seq_ch),
    .rd_data (th_q)
  );
  channel_settings_mem #(.WIDTH(32), .DEPTH(NCH), .AW(3)) u_don (
    .clk     (clk),
    .wr_en   (don_we),
    .wr_addr (ch_sel),
    .wr_data (wdata),
    .rd_addr (seq_ch),
    .rd_data (don_q)
  );
  channel_settings_mem #(.WIDTH(32), .DEPTH(NCH), .AW(3)) u_doff (
    .clk     (clk),
    .wr_en   (doff_we),
    .wr_addr (ch_sel),
    .wr_data (wdata),
    .rd_addr (seq_ch),
    .rd_data (doff_q)
  );

  // shadow copies of loaded settings so reads need no second port
  reg [31:0] th_shadow [0:NCH-1];
  reg [NCH-1:0] th_loaded; // unloaded channels use the reset thresholds
  reg [NCH-1:0] don_loaded;  // unloaded channels have no activation delay
  reg [NCH-1:0] doff_loaded; // unloaded channels have no drop-off delay

  // latched voltage snapshot, taken once per scan
  reg [NCH*VW-1:0] snap;
  reg [NCH-1:0]    raw;       // hysteresis state before delays
  reg [NCH-1:0]    cond;      // delayed, polarity-applied state
  reg [15:0]       dcnt [0:NCH-1]; // scans elapsed toward a change

  // thresholds used for the evaluated channel, with reset defaults and ac override
  wire [15:0] act_th = th_loaded[seq_ch] ? th_q[`TH_ACT_LSB+15:`TH_ACT_LSB] : `TH_ACT_RESET;
  wire [15:0] rel_set = th_loaded[seq_ch] ? th_q[`TH_REL_LSB+15:`TH_REL_LSB] : `TH_REL_RESET;
  wire [15:0] rel_th = ac_mode[seq_ch] ? act_th / AC_DIV : rel_set;
  wire [VW-1:0] v_ch = snap[seq_ch*VW +: VW];
  wire        energized = raw_next(v_ch, act_th, rel_th, raw[seq_ch]);
  wire        want = energized ^ pol_nc[seq_ch];
  // delays read as zero until software loads them, so unset words only leak when a load lands in that channel's ST_READ cycle
  wire [15:0] on_scans  = don_loaded[seq_ch] ? don_q[15:0] : 16'h0000;
  wire [15:0] off_set   = doff_loaded[seq_ch] ? doff_q[15:0] : 16'h0000;
  // drop delay in scans; ac mode adds 30 ms
  wire [15:0] off_scans = off_set + (ac_mode[seq_ch] ? AC_SCANS : 16'h0000);

  // per-scan sequencer: snapshot, then evaluate each channel in turn
  integer i;
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      seq_state <= ST_IDLE;
      seq_ch    <= 3'd0;
      snap      <= {NCH*VW{1'b0}};
      raw       <= {NCH{1'b0}};
      cond      <= {NCH{1'b0}};
      for (i = 0; i < NCH; i = i + 1)
        dcnt[i] <= 16'h0000;
    end else begin
      case (seq_state)
        ST_IDLE: begin
          if (tick) begin
            snap      <= volt_stable;
            seq_ch    <= 3'd0;
            seq_state <= ST_READ;
          end
        end
        ST_READ: begin
          // memory read data valid next cycle
          seq_state <= ST_EVAL;
        end
        ST_EVAL: begin
          raw[seq_ch] <= energized;
          if (want == cond[seq_ch]) begin
            dcnt[seq_ch] <= 16'h0000;
          end else if (want && dcnt[seq_ch] >= on_scans) begin
            cond[seq_ch] <= 1'b1;
            dcnt[seq_ch] <= 16'h0000;
          end else if (!want && dcnt[seq_ch] >= off_scans) begin
            cond[seq_ch] <= 1'b0;
            dcnt[seq_ch] <= 16'h0000;
          end else begin
            dcnt[seq_ch] <= dcnt[seq_ch] + 16'h0001;
          end
          if (seq_ch == NCH - 1) begin
            seq_state <= ST_IDLE;
          end else begin
            seq_ch    <= seq_ch + 3'd1;
            seq_state <= ST_READ;
          end
        end
        default: seq_state <= ST_IDLE;
      endcase
    end
  end

  // reported pipeline: one scan stage each for state, internal use, relay routing
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      scan_state        <= {NCH{1'b0}};
      internal_state    <= {NCH{1'b0}};
      relay_route_state <= {NCH{1'b0}};
      scan_tick         <= 1'b0;
    end else begin
      scan_tick <= tick;
      if (tick) begin
        scan_state        <= cond;
        internal_state    <= scan_state;
        relay_route_state <= internal_state;
      end
    end
  end

  // control register writes and loaded flags for the settings
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pol_nc    <= {NCH{1'b0}};
      ac_mode   <= {NCH{1'b0}};
      ch_base   <= 8'h00;
      th_loaded <= {NCH{1'b0}};
      don_loaded  <= {NCH{1'b0}};
      doff_loaded <= {NCH{1'b0}};
    end else if (wr) begin
      if (addr == `REG_CTRL) begin
        pol_nc  <= wdata[`CTRL_POL_LSB +: NCH];
        ac_mode <= wdata[`CTRL_AC_LSB +: NCH];
        ch_base <= wdata[`CTRL_BASE_LSB +: 8];
      end
      if (th_we)
        th_loaded[ch_sel] <= 1'b1;
      // delay words count as loaded once written
      if (don_we)
        don_loaded[ch_sel] <= 1'b1;
      if (doff_we)
        doff_loaded[ch_sel] <= 1'b1;
    end
  end

  // shadow array has no reset: only read after its loaded bit is set
  always @(posedge clk) begin
    if (th_we)
      th_shadow[ch_sel] <= wdata;
  end

  // shadow copies of delays for readback
  reg [31:0] don_shadow  [0:NCH-1];
  reg [31:0] doff_shadow [0:NCH-1];
  always @(posedge clk) begin
    if (don_we)
      don_shadow[ch_sel] <= wdata;
    if (doff_we)
      doff_shadow[ch_sel] <= wdata;
  end

  // read mux, data registered one cycle after the strobe; unmapped reads zero
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata <= 32'h0000_0000;
    end else if (rd) begin
      rdata <= 32'h0000_0000;
      if (addr == `REG_CTRL)
        rdata <= {8'h00, ch_base, ac_mode, pol_nc};
      else if (addr == `REG_STATUS)
        rdata <= {24'h00_0000, scan_state};
      else if (addr == `REG_INT_STATE)
        rdata <= {24'h00_0000, internal_state};
      else if (addr == `REG_OUT_STATE)
        rdata <= {24'h00_0000, relay_route_state};
      else if (ch_space) begin
        case (ch_field)
          `CH_THRESH_OFS:
            rdata <= th_loaded[ch_sel] ? th_shadow[ch_sel]
                                       : {`TH_REL_RESET, `TH_ACT_RESET};
          `CH_DELAY_ON_OFS:
            rdata <= don_loaded[ch_sel] ? don_shadow[ch_sel] : 32'h0000_0000;
          `CH_DELAY_OFF_OFS:
            rdata <= doff_loaded[ch_sel] ? doff_shadow[ch_sel] : 32'h0000_0000;
          default:
            rdata <= {{(32-VW){1'b0}}, volt_stable[ch_sel*VW +: VW]};
        endcase
      end
    end
  end

endmodule

//--- tb/input_scan_chk.sv
// input_scan_chk.sv: port-level assertions for the input scan block
// assumes one clock, the async active-low reset and a bind onto the block
`timescale 1ns/1ps
module input_scan_chk #(
  parameter NCH      = 8,
  parameter SCAN_CYC = 50,
  parameter VW       = 8
) (
  input wire logic           clk,
  input wire logic           nrst,
  input wire logic [7:0]     addr,
  input wire logic [31:0]    wdata,
  input wire logic           wr,
  input wire logic           rd,
  input wire logic [31:0]    rdata,
  input wire logic [NCH-1:0] scan_state,
  input wire logic [NCH-1:0] internal_state,
  input wire logic [NCH-1:0] relay_route_state,
  input wire logic [7:0]     first_channel_num,
  input wire logic           scan_tick
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  reg [31:0] gap;  // cycles since the last scan pulse
  reg        seen; // first pulse has no predecessor to measure from
  // gap counter between scan pulses
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      gap  <= 32'h0000_0000;
      seen <= 1'b0;
    end else if (scan_tick) begin
      gap  <= 32'h0000_0000;
      seen <= 1'b1;
    end else begin
      gap <= gap + 32'h0000_0001;
    end
  end
  AST_TICK_GAP: assert property (scan_tick && seen |-> gap == SCAN_CYC - 1)
    else $error("scan pulse spacing wrong");
  AST_TICK_PULSE: assert property (scan_tick |=> !scan_tick)
    else $error("scan pulse longer than one cycle");
  AST_STATE_ON_SCAN: assert property (!$stable(scan_state) |-> scan_tick)
    else $error("state moved between scans");
  AST_INT_FOLLOWS: assert property (
    !$stable(internal_state) |-> scan_tick && internal_state == $past(scan_state))
    else $error("internal state not one scan behind");
  AST_RELAY_FOLLOWS: assert property (
    !$stable(relay_route_state) |-> scan_tick && relay_route_state == $past(internal_state))
    else $error("relay state not one scan behind");
  AST_FIRST_NUM: assert property (
    wr && addr == 8'h00 |=> first_channel_num == $past(wdata[23:16]) + 8'h01)
    else $error("first channel number wrong");
  AST_RD_STATUS: assert property (
    rd && addr == 8'h01 |=> rdata[NCH-1:0] == $past(scan_state))
    else $error("status read wrong");
  AST_RD_RELAY: assert property (
    rd && addr == 8'h03 |=> rdata[NCH-1:0] == $past(relay_route_state))
    else $error("relay read wrong");
endmodule
bind input_scan input_scan_chk #(.NCH(NCH), .SCAN_CYC(SCAN_CYC), .VW(VW)) u_input_scan_chk (
  .clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .scan_state(scan_state), .internal_state(internal_state),
  .relay_route_state(relay_route_state), .first_channel_num(first_channel_num),
  .scan_tick(scan_tick));

//--- tb/field_wiring.sv
// field_wiring.sv: field side of the card, eight channel voltage codes
// assumes the bench sets a level per channel; the wire follows one clock later
`timescale 1ns/1ps
module field_wiring (
  input  wire logic        clk,
  input  wire logic [63:0] level,
  output logic      [63:0] volt_in
);
  // energized wiring holds its voltage until the bench moves it
  always @(posedge clk) begin
    volt_in <= level;
  end
endmodule

//--- tb/tb_top.sv
// tb_top.sv: self-checking bench with an integer model of the channel conditioning
// assumes a shortened scan period; config is written mid-scan, volts right after a scan
`timescale 1ns/1ps
module tb_top;
  localparam SC = 100; // shortened scan period
  logic clk, nrst, wr, rd, scan_tick;
  logic [7:0]  addr, scan_state, internal_state, relay_route_state, first_channel_num;
  logic [31:0] wdata, rdata;
  logic [63:0] level, volt_in, vsnap;
  logic [7:0]  nc, ac, p_nc, p_ac, h1, h2, e, base; // model config, pending config, history
  int act[8], rel[8], don[8], doff[8], p_act[8], p_rel[8], p_don[8], p_doff[8];
  int en[8], st[8], cnt[8];
  int fail_count, n_checks;
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin fail_count++; \
  $display("[ERR] %0t got %h expected %h", $time, a, b); end end
  input_scan #(.NCH(8), .SCAN_CYC(SC), .VW(8)) u_input_scan (.clk(clk), .nrst(nrst),
    .volt_in(volt_in), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .scan_state(scan_state), .internal_state(internal_state),
    .relay_route_state(relay_route_state), .first_channel_num(first_channel_num),
    .scan_tick(scan_tick));
  field_wiring u_field_wiring (.clk(clk), .level(level), .volt_in(volt_in));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // one channel, one scan: hysteresis, polarity, then whole-scan delays
  task automatic step(int c);
    int v, r, tg, dl;
    v = vsnap[c*8 +: 8];
    r = ac[c] ? act[c] / 10 : rel[c]; // ac forces release to a tenth
    if (v > act[c]) en[c] = 1;
    else if (v < r) en[c] = 0;
    tg = en[c] ^ nc[c];
    dl = tg ? don[c] : doff[c] + (ac[c] ? 6 : 0); // 30 ms is six scans
    if (tg == st[c]) cnt[c] = 0;
    else if (cnt[c] >= dl) begin st[c] = tg; cnt[c] = 0; end
    else cnt[c]++;
  endtask
  // model result compared at every scan; config lands one scan after it is written
  always @(posedge clk) begin
    if (nrst && scan_tick) begin
      for (int c = 0; c < 8; c++) begin step(c); e[c] = st[c][0]; end
      `CHK(scan_state, e)
      `CHK(internal_state, h1)
      `CHK(relay_route_state, h2)
      h2 = h1;
      h1 = e;
      vsnap = volt_in;
      act = p_act; rel = p_rel; don = p_don; doff = p_doff; nc = p_nc; ac = p_ac;
    end
  end
  task automatic wr_reg(logic [7:0] a, logic [31:0] d);
    wr <= 1'b1; addr <= a; wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd_chk(logic [7:0] a, logic [31:0] x);
    rd <= 1'b1; addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    `CHK(rdata, x)
  endtask
  task automatic wait_tick();
    int n;
    n = 0;
    @(posedge clk);
    while (scan_tick !== 1'b1 && n < 3*SC) begin n++; @(posedge clk); end
    if (n >= 3*SC) `CHK(1'b0, 1'b1)
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // watchdog: five phases of fourteen scans fit well inside this
  initial begin
    #100000;
    fail_count++;
    wrap_up();
  end
  initial begin
    int r, a, s;
    nrst = 1'b0; wr = 1'b0; rd = 1'b0; addr = 8'h00; wdata = 32'h0000_0000;
    level = 64'h0; vsnap = 64'h0; h1 = 8'h00; h2 = 8'h00;
    nc = 8'h00; ac = 8'h00; p_nc = 8'h00; p_ac = 8'h00;
    for (int c = 0; c < 8; c++) begin p_act[c] = 88; p_rel[c] = 60; end
    act = p_act; rel = p_rel;
    void'($urandom(72));
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    `CHK(first_channel_num, 8'h01)
    rd_chk(8'h10, 32'h003C_0058);
    rd_chk(8'h80, 32'h0000_0000);
    rd_chk(8'h11, 32'h0000_0000);
    for (int p = 0; p < 5; p++) begin
      wait_tick();
      repeat (20) @(posedge clk);
      if (p > 0) begin
        for (int c = 0; c < 8; c++) begin
          p_act[c] = 20 + $urandom % 200;
          p_rel[c] = p_act[c] - 1 - $urandom % 15;
          p_don[c] = $urandom % 3;
          p_doff[c] = $urandom % 3;
          wr_reg(8'h10 + 4*c, {p_rel[c][15:0], p_act[c][15:0]});
          wr_reg(8'h11 + 4*c, p_don[c]);
          wr_reg(8'h12 + 4*c, p_doff[c]);
        end
        p_nc = $urandom;
        p_ac = $urandom;
        base = $urandom;
        wr_reg(8'h00, {8'h00, base, p_ac, p_nc});
        `CHK(first_channel_num, base + 8'h01)
        rd_chk(8'h2C, {p_rel[7][15:0], p_act[7][15:0]});
        rd_chk(8'h2D, p_don[7]);
        rd_chk(8'h2E, p_doff[7]);
      end
      for (int k = 0; k < 14; k++) begin
        wait_tick();
        for (int c = 0; c < 8; c++) begin
          a = p_act[c];
          r = p_ac[c] ? a / 10 : p_rel[c];
          s = $urandom % 5;
          level[c*8 +: 8] <= (s == 0) ? 0 : (s == 1) ? r - 1 : (s == 2) ? (r + a) / 2 :
                             (s == 3) ? a + 1 : 255;
        end
        repeat (4) @(posedge clk);
        rd_chk(8'h01, {24'h00_0000, h1});
        rd_chk(8'h02, {24'h00_0000, h2});
        rd_chk(8'h13 + 4*(k%8), {24'h00_0000, level[(k%8)*8 +: 8]});
      end
    end
    wrap_up();
  end
endmodule
